/* File: dv/ddr_port_properties.sv */
// concurrent checks on the sram port pins and the register port
// assumes a bind onto ddr_sram_byte_write_port, k clocks running
`timescale 1ns/1ps
module ddr_port_properties
	import ddr_port_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic k_clk_in,
	input wire logic k_n_clk_in,
	input wire logic load_select_n_in,
	input wire logic read_write_in,
	input wire logic dq_oe_out
);
	// ------------------------------------------------------------
	// helper state
	// ------------------------------------------------------------
	logic en;
	logic rd1;
	logic rd2;

	// mirror of the enable bit; the k side lags, so loads must wait
	always_ff @(posedge clk_sys_in)
		if (sys_rst_in)
			en <= 1'h1;
		else if (reg_write_in && reg_addr_in == CTRL_OFFSET)
			en <= reg_wdata_in[CTRL_ENABLE_BIT];

	// read loads delayed two k edges: the cycle their words stand
	always_ff @(posedge k_clk_in)
		rd1 <= !sys_rst_in && !load_select_n_in && read_write_in && en;
	always_ff @(posedge k_clk_in)
		rd2 <= rd1 && !sys_rst_in;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	oe_word0_a: assert property (@(posedge k_n_clk_in)
		disable iff (sys_rst_in) dq_oe_out == rd2)
		else $error("drive enable wrong in first word phase");
	oe_word1_a: assert property (@(posedge k_clk_in)
		disable iff (sys_rst_in) dq_oe_out == rd2)
		else $error("drive enable wrong in second word phase");
	nop_float_a: assert property (@(posedge k_clk_in)
		disable iff (sys_rst_in) load_select_n_in |-> ##2 !dq_oe_out)
		else $error("pins driven after an idle cycle");
	write_quiet_a: assert property (@(posedge k_clk_in)
		disable iff (sys_rst_in)
		!load_select_n_in && !read_write_in |-> ##2 !dq_oe_out)
		else $error("pins driven after a write load");
	read_drives_a: assert property (@(posedge k_clk_in)
		disable iff (sys_rst_in)
		!load_select_n_in && read_write_in && en |-> ##2 dq_oe_out)
		else $error("read load not driven");
	burst_two_a: assert property (@(posedge k_clk_in)
		disable iff (sys_rst_in)
		(!load_select_n_in && read_write_in && en) ##1 load_select_n_in
		|-> ##1 dq_oe_out ##1 !dq_oe_out)
		else $error("read burst not exactly two words");
	rdata_idle_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		!$past(reg_read_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside its cycle");
	ctrl_read_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		$past(reg_read_in && reg_addr_in == CTRL_OFFSET)
		|-> reg_rdata_out == {31'h0, en})
		else $error("control readback wrong");
endmodule // ddr_port_properties

bind ddr_sram_byte_write_port ddr_port_properties u_props (
	.clk_sys_in,
	.sys_rst_in,
	.reg_addr_in,
	.reg_wdata_in,
	.reg_write_in,
	.reg_read_in,
	.reg_rdata_out,
	.k_clk_in,
	.k_n_clk_in,
	.load_select_n_in,
	.read_write_in,
	.dq_oe_out
);

/* File: dv/mem_ctrl_model.sv */
// controller-side model: link clocks and the sram command/data bus
// assumes one caller process; one load per k cycle at most
`timescale 1ns/1ps
module mem_ctrl_model
(
	input wire logic park_in,
	output logic k_out,
	output logic k_n_out,
	output logic c_out,
	output logic c_n_out,
	output logic [19:0] addr_out,
	output logic load_n_out,
	output logic rw_out,
	output logic [3:0] mask_n_out,
	output logic [17:0] dq_out
);
	// link clock, phase unrelated to the system clock; the link clocks never
	// stop here; only the output pair below is held at the matched parking level, by park_in
	initial
	begin
		k_out = 1'h0;
		addr_out = 20'h0;
		load_n_out = 1'h1;
		rw_out = 1'h0;
		mask_n_out = 4'hf;
		dq_out = 18'h0;
		#3;
		forever #80 k_out = ~k_out;
	end
	assign k_n_out = ~k_out;
	// output pair trails k slightly, or is parked high
	assign #1 c_out = park_in | k_out;
	assign #1 c_n_out = park_in | k_n_out;

	// load and beat 0 held across k, beat 1 across k#
	task automatic wr(input logic [19:0] a, input logic [17:0] d0,
		input logic [17:0] d1, input logic [3:0] m0, input logic [3:0] m1);
		@(posedge k_n_out);
		addr_out <= a;
		load_n_out <= 1'h0;
		rw_out <= 1'h0;
		dq_out <= d0;
		mask_n_out <= m0;
		@(posedge k_out);
		load_n_out <= 1'h1;
		dq_out <= d1;
		mask_n_out <= m1;
	endtask

	// read or idle cycle; unused data lines toggle, never hold
	task automatic op(input logic ld_n, input logic rw,
		input logic [19:0] a, input logic [3:0] m);
		@(posedge k_n_out);
		addr_out <= a;
		load_n_out <= ld_n;
		rw_out <= rw;
		mask_n_out <= m;
		dq_out <= ~dq_out;
		@(posedge k_out);
		load_n_out <= 1'h1;
		dq_out <= ~dq_out;
	endtask
endmodule // mem_ctrl_model

/* File: dv/tb.sv */
// self-checking bench for the sram data port
// assumes the controller model drives the link side
`timescale 1ns/1ps
module tb;
	import ddr_port_pkg::*;
	logic clk_sys_in = 1'h0;
	logic sys_rst_in = 1'h1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'h0;
	logic reg_read = 1'h0;
	logic park = 1'h0;
	logic en = 1'h1;
	logic [31:0] rdata;
	logic k, kn, c, cn, ld_n, rw, oe;
	logic [19:0] addr;
	logic [3:0] m;
	logic [17:0] dq_w, dq_q;
	logic [17:0] mem [0:63];
	logic [17:0] expq [$];
	int err_count, comparisons, nwr, nrd, i;

	// system clock
	initial
		forever #2 clk_sys_in = ~clk_sys_in;

	ddr_sram_byte_write_port u_dut (.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr),
		.reg_wdata_in(reg_wdata), .reg_write_in(reg_write),
		.reg_read_in(reg_read), .reg_rdata_out(rdata), .k_clk_in(k),
		.k_n_clk_in(kn), .c_clk_in(c), .c_n_clk_in(cn), .addr_in(addr),
		.load_select_n_in(ld_n), .read_write_in(rw),
		.lane_zero_write_mask_n_in(m[0]), .lane_one_write_mask_n_in(m[1]),
		.lane_two_write_mask_n_in(m[2]),
		.lane_three_write_mask_n_in(m[3]), .dq_in(dq_w), .dq_out(dq_q),
		.dq_oe_out(oe));
	mem_ctrl_model u_ctrl (.park_in(park), .k_out(k), .k_n_out(kn),
		.c_out(c), .c_n_out(cn), .addr_out(addr), .load_n_out(ld_n),
		.rw_out(rw), .mask_n_out(m), .dq_out(dq_w));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge clk_sys_in);
		reg_write <= 1'h0;
		if (a == CTRL_OFFSET)
			en = d[CTRL_ENABLE_BIT];
	endtask

	task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk_sys_in);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge clk_sys_in);
		reg_read <= 1'h0;
		@(posedge clk_sys_in);
		check(rdata, exp);
	endtask

	function automatic logic [17:0] merge(input logic [17:0] o,
		input logic [17:0] d, input logic [3:0] mk);
		merge = o;
		if (!mk[0])
			merge[8:0] = d[8:0];
		if (!mk[1])
			merge[17:9] = d[17:9];
	endfunction

	// the reference array follows only loads the port accepts
	task automatic w(input logic [5:0] a, input logic [17:0] d0,
		input logic [17:0] d1, input logic [3:0] m0, input logic [3:0] m1);
		if (en)
		begin
			mem[a] = merge(mem[a], d0, m0);
			mem[a ^ 6'h1] = merge(mem[a ^ 6'h1], d1, m1);
			nwr++;
		end
		u_ctrl.wr({14'h0, a}, d0, d1, m0, m1);
	endtask

	task automatic r(input logic [5:0] a);
		if (en)
		begin
			expq.push_back(mem[a]);
			expq.push_back(mem[a ^ 6'h1]);
			nrd++;
		end
		u_ctrl.op(1'h0, 1'h1, {14'h0, a}, 4'hf);
	endtask

	// words sampled mid half-cycle, settled for either launch pair
	always @(posedge k or posedge kn)
	begin
		#40;
		if (oe === 1'h1)
		begin
			if (expq.size() == 0)
				check({31'h0, oe}, 32'h0);
			else
				check({14'h0, dq_q}, {14'h0, expq.pop_front()});
		end
	end

	// watchdog well beyond the expected run
	initial
	begin
		#60000;
		err_count++;
		finish_test;
	end

	initial
	begin
		repeat (4) @(posedge k);
		@(posedge clk_sys_in);
		sys_rst_in <= 1'h0;
		repeat (3) @(posedge k);
		reg_rd(CTRL_OFFSET, 32'h1);
		reg_rd(4'h8, 32'h0);
		reg_wr(4'hc, 32'hffff_ffff);
		reg_rd(4'hc, 32'h0);
		// back-to-back full writes, odd start pairs with the even word
		w(6'h10, 18'h2a5a5, 18'h15a5a, 4'h0, 4'h0);
		w(6'h21, 18'h3ffff, 18'h00001, 4'h0, 4'h0);
		u_ctrl.op(1'h1, 1'h0, 20'h0, 4'hf);
		r(6'h10);
		r(6'h21);
		// every mask code, with different codes on the two beats
		for (i = 0; i < 4; i++)
		begin
			w(6'h10, 18'h0c30c ^ i, 18'h30cf3 + i, 4'hc | i, 4'hf - i);
			u_ctrl.op(1'h1, 1'h0, 20'h10, 4'h0);
			r(6'h10);
		end
		// masks and data wiggle with no write loaded
		u_ctrl.op(1'h1, 1'h0, 20'h10, 4'h0);
		u_ctrl.op(1'h1, 1'h1, 20'h10, 4'h0);
		r(6'h10);
		// output pair parked high moves launch to the input pair
		repeat (3) @(posedge k);
		park <= 1'h1;
		repeat (4) @(posedge k);
		r(6'h21);
		r(6'h10);
		// loads are ignored while the port is disabled
		repeat (3) @(posedge k);
		reg_wr(CTRL_OFFSET, 32'h0);
		repeat (3) @(posedge k);
		r(6'h10);
		w(6'h10, 18'h0, 18'h0, 4'h0, 4'h0);
		repeat (3) @(posedge k);
		reg_wr(CTRL_OFFSET, 32'h1);
		reg_rd(CTRL_OFFSET, 32'h1);
		repeat (3) @(posedge k);
		r(6'h10);
		repeat (4) @(posedge k);
		reg_rd(STATUS_OFFSET, {nrd[15:0], nwr[15:0]});
		check(expq.size(), 32'h0);
		finish_test;
	end
endmodule // tb

/* File: rtl/ddr_launch_stage.sv */
// double-data-rate output stage for the read data pins
// assumes its clock pair is mesochronous with the input clock pair
`timescale 1ns/1ps
module ddr_launch_stage
	import ddr_port_pkg::*;
#(
	parameter int DATA_W = 18
)
(
	input wire logic rise_clk_in,
	input wire logic fall_clk_in,
	input wire logic rst_in,
	input wire launch_type launch_in,
	output logic [DATA_W-1:0] q_out,
	output logic oe_out
);

	logic [DATA_W-1:0] rise_q;
	logic [DATA_W-1:0] fall_q;
	logic [DATA_W-1:0] rise_w1;
	logic rise_oe;
	logic fall_oe;

	// ------------------------------------------------------------
	// first word on the true edge, idle cycles float the pins
	// ------------------------------------------------------------
	always_ff @(posedge rise_clk_in)
	begin
		if (rst_in)
		begin
			rise_oe <= 1'b0;
			rise_q <= '0;
			rise_w1 <= '0;
		end
		else
		begin
			rise_oe <= launch_in.go;
			rise_q <= launch_in.word0[DATA_W-1:0];
			// both words taken together, so a following load cannot
			// replace the second word before it leaves
			rise_w1 <= launch_in.word1[DATA_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// second word on the complement edge of the same pair
	// ------------------------------------------------------------
	always_ff @(posedge fall_clk_in)
	begin
		if (rst_in)
		begin
			fall_oe <= 1'b0;
			fall_q <= '0;
		end
		else
		begin
			fall_oe <= rise_oe;
			fall_q <= rise_w1;
		end
	end

	// pin phase follows the true clock level, as in an output ddr cell
	assign q_out = rise_clk_in ? rise_q : fall_q;
	assign oe_out = rise_clk_in ? rise_oe : fall_oe;

endmodule // ddr_launch_stage

/* File: rtl/ddr_port_pkg.sv */
// shared constants and types for the double-data-rate sram data port
// assumes a 9-bit lane granularity and at most four lanes
package ddr_port_pkg;

	// ------------------------------------------------------------
	// lane geometry
	// ------------------------------------------------------------
	localparam int LANE_W = 9;
	localparam int MAX_LANES = 4;
	localparam int MAX_DATA_W = LANE_W * MAX_LANES;

	// ------------------------------------------------------------
	// software port map (byte offsets, 32-bit words)
	// ------------------------------------------------------------
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic CTRL_ENABLE_RESET = 1'h1;
	localparam int STATUS_WRITES_LSB = 0;
	localparam int STATUS_READS_LSB = 16;
	localparam int COUNT_W = 16;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

	// ------------------------------------------------------------
	// one captured write beat: data and active-low lane masks
	// ------------------------------------------------------------
	typedef struct packed {
		logic [MAX_DATA_W-1:0] data;
		logic [MAX_LANES-1:0] mask_n;
	} beat_type;

	localparam beat_type BEAT_RESET = '{data: 36'h0, mask_n: 4'hf};

	// ------------------------------------------------------------
	// one pair of read words handed to the launch stages
	// ------------------------------------------------------------
	typedef struct packed {
		logic go;
		logic [MAX_DATA_W-1:0] word0;
		logic [MAX_DATA_W-1:0] word1;
	} launch_type;

	localparam launch_type LAUNCH_RESET = '{go: 1'h0, word0: 36'h0,
		word1: 36'h0};

endpackage

/* File: rtl/ddr_sram_byte_write_port.sv */
// double-data-rate sram data port with per-lane write masking
// assumes the input clock pair is the link clock and the output clock
// pair is either running near it or parked high
//
// Contract
// - lane zero enabled alone stores only data bits 0 to 8.
// - lane one enabled alone stores only data bits 9 to 17.
// - both lower masks low stores all eighteen bits of the beat.
// - both masks high writes nothing and leaves the word unchanged.
// - masks only act inside a loaded write burst.
// - masks are judged separately on every beat.
// - wide variant adds lane two (bits 18-26) and three (27-35).
// - write data taken on true and complement input clock edges.
// - read data on output clock pair, else on input pair if parked high.
// - load and read/write select sampled only on the true input edge.
// - data pins float from power-up until a read.
// - load low, read/write low starts a write; beats at true then complement.
// - load low, read/write high starts a read of two words.
// - only the lowest address bit advances, inverted, two words per burst.
`timescale 1ns/1ps
module ddr_sram_byte_write_port
	import ddr_port_pkg::*;
#(
	parameter int DATA_W = 18,
	parameter int ADDR_W = 20
)
(
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [31:0] reg_rdata_out,
	input wire logic k_clk_in,
	input wire logic k_n_clk_in,
	input wire logic c_clk_in,
	input wire logic c_n_clk_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic load_select_n_in,
	input wire logic read_write_in,
	input wire logic lane_zero_write_mask_n_in,
	input wire logic lane_one_write_mask_n_in,
	input wire logic lane_two_write_mask_n_in,
	input wire logic lane_three_write_mask_n_in,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe_out
);

	localparam int LANES = DATA_W / LANE_W;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// overlay a beat on a stored word, lane by lane
	function automatic logic [DATA_W-1:0] merge_beat(
		input logic [DATA_W-1:0] old_word,
		input beat_type beat
	);
		logic [DATA_W-1:0] result;
		result = old_word;
		for (int l = 0; l < LANES; l++)
		begin
			if (!beat.mask_n[l])
				result[l*LANE_W +: LANE_W] = beat.data[l*LANE_W +: LANE_W];
		end
		return result;
	endfunction

	// second burst address: lowest bit inverted, upper bits kept
	function automatic logic [ADDR_W-1:0] burst_next(
		input logic [ADDR_W-1:0] a
	);
		return {a[ADDR_W-1:1], ~a[0]};
	endfunction

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [MAX_LANES-1:0] pin_mask_n;
	logic [MAX_DATA_W-1:0] pin_data;
	logic k_rst_meta;
	logic k_rst;
	logic enable_meta;
	logic enable_k;
	logic park_meta_c;
	logic park_meta_cn;
	logic park_c;
	logic park_cn;
	logic parked;
	logic wr_open;
	logic wr_commit;
	logic [ADDR_W-1:0] wr_addr;
	beat_type beat0;
	beat_type beat1;
	logic [DATA_W-1:0] commit_word0;
	logic [DATA_W-1:0] commit_word1;
	logic [ADDR_W-1:0] rd_addr1;
	logic read_load;
	logic write_load;
	launch_type launch;
	launch_type next_launch;
	launch_type launch_hold;
	logic wr_tog;
	logic rd_tog;
	logic [DATA_W-1:0] q_c;
	logic [DATA_W-1:0] q_k;
	logic oe_c;
	logic oe_k;
	logic ctrl_enable;
	logic [2:0] wr_tog_sync;
	logic [2:0] rd_tog_sync;
	logic [COUNT_W-1:0] write_count;
	logic [COUNT_W-1:0] read_count;

	// ------------------------------------------------------------
	// pin gathering
	// ------------------------------------------------------------
	// upper lanes only exist on the wide variant
	assign pin_mask_n = {lane_three_write_mask_n_in,
		lane_two_write_mask_n_in,
		lane_one_write_mask_n_in,
		lane_zero_write_mask_n_in};
	assign pin_data = MAX_DATA_W'(dq_in);

	// ------------------------------------------------------------
	// link domain: reset and enable crossings
	// ------------------------------------------------------------
	// no reset pin on the memory side, so the system reset is carried over
	always_ff @(posedge k_clk_in)
	begin
		k_rst_meta <= sys_rst_in;
		k_rst <= k_rst_meta;
	end

	// enable level from software, two flops
	always_ff @(posedge k_clk_in)
	begin
		if (k_rst)
		begin
			enable_meta <= CTRL_ENABLE_RESET;
			enable_k <= CTRL_ENABLE_RESET;
		end
		else
		begin
			enable_meta <= ctrl_enable;
			enable_k <= enable_meta;
		end
	end

	// ------------------------------------------------------------
	// output clock parking detect
	// ------------------------------------------------------------
	// sampled mid-cycle, where a running output clock sits low
	always_ff @(negedge k_clk_in)
	begin
		if (k_rst)
		begin
			park_meta_c <= 1'b0;
			park_meta_cn <= 1'b0;
			park_c <= 1'b0;
			park_cn <= 1'b0;
		end
		else
		begin
			park_meta_c <= c_clk_in;
			park_meta_cn <= c_n_clk_in;
			park_c <= park_meta_c;
			park_cn <= park_meta_cn;
		end
	end

	assign parked = park_c & park_cn;

	// ------------------------------------------------------------
	// command decode on the true input edge
	// ------------------------------------------------------------
	// load high decodes as nothing whatever the read/write level
	assign write_load = enable_k & ~load_select_n_in & ~read_write_in;
	assign read_load = enable_k & ~load_select_n_in & read_write_in;

	// burst state and first beat, both on the true edge only
	always_ff @(posedge k_clk_in)
	begin
		if (k_rst)
		begin
			wr_open <= 1'b0;
			wr_commit <= 1'b0;
			wr_addr <= '0;
			beat0 <= BEAT_RESET;
		end
		else
		begin
			wr_open <= write_load;
			wr_commit <= wr_open;
			if (write_load)
				wr_addr <= addr_in;
			// masks outside a loaded burst are forced off
			beat0.data <= pin_data;
			beat0.mask_n <= write_load ? pin_mask_n : 4'hf;
		end
	end

	// second beat on the complement input edge
	always_ff @(posedge k_n_clk_in)
	begin
		if (k_rst)
			beat1 <= BEAT_RESET;
		else
		begin
			beat1.data <= pin_data;
			beat1.mask_n <= wr_open ? pin_mask_n : 4'hf;
		end
	end

	// ------------------------------------------------------------
	// late write commit
	// ------------------------------------------------------------
	// both beats are written together at the next true edge, before a
	// following load overwrites them; this keeps the array on one clock
	// edge at the cost of forwarding to a read loaded on that edge
	assign commit_word0 = merge_beat(mem[wr_addr], beat0);
	assign commit_word1 = merge_beat(mem[burst_next(wr_addr)], beat1);

	// array write: two words per burst, then the burst is over
	always_ff @(posedge k_clk_in)
	begin
		if (wr_open)
		begin
			mem[wr_addr] <= commit_word0;
			mem[burst_next(wr_addr)] <= commit_word1;
		end
	end

	// ------------------------------------------------------------
	// read fetch with coherency against a commit in flight
	// ------------------------------------------------------------
	assign rd_addr1 = burst_next(addr_in);

	always_comb
	begin
		next_launch = launch;
		next_launch.go = read_load;
		if (read_load)
		begin
			next_launch.word0 = MAX_DATA_W'(mem[addr_in]);
			next_launch.word1 = MAX_DATA_W'(mem[rd_addr1]);
			if (wr_open && addr_in == wr_addr)
			begin
				next_launch.word0 = MAX_DATA_W'(commit_word0);
				next_launch.word1 = MAX_DATA_W'(commit_word1);
			end
			else if (wr_open && addr_in == burst_next(wr_addr))
			begin
				next_launch.word0 = MAX_DATA_W'(commit_word1);
				next_launch.word1 = MAX_DATA_W'(commit_word0);
			end
		end
	end

	always_ff @(posedge k_clk_in)
	begin
		if (k_rst)
			launch <= LAUNCH_RESET;
		else
			launch <= next_launch;
	end

	// copy for the output pair, which rises just after k and would
	// otherwise pick up a load one cycle early
	always_ff @(posedge k_clk_in)
	begin
		if (k_rst)
			launch_hold <= LAUNCH_RESET;
		else
			launch_hold <= launch;
	end

	// event toggles for the software counters
	always_ff @(posedge k_clk_in)
	begin
		if (k_rst)
		begin
			wr_tog <= 1'b0;
			rd_tog <= 1'b0;
		end
		else
		begin
			if (wr_commit)
				wr_tog <= ~wr_tog;
			if (read_load)
				rd_tog <= ~rd_tog;
		end
	end

	// ------------------------------------------------------------
	// launch stages and pin selection
	// ------------------------------------------------------------
	// output clock pair stage; fed one k cycle later, so the hand-off
	// relies on the output pair rising shortly after the input pair
	ddr_launch_stage #(
		.DATA_W(DATA_W)
	) launch_on_c (
		.rise_clk_in(c_clk_in),
		.fall_clk_in(c_n_clk_in),
		.rst_in(k_rst),
		.launch_in(launch_hold),
		.q_out(q_c),
		.oe_out(oe_c)
	);

	// fallback stage on the input clock pair
	ddr_launch_stage #(
		.DATA_W(DATA_W)
	) launch_on_k (
		.rise_clk_in(k_clk_in),
		.fall_clk_in(k_n_clk_in),
		.rst_in(k_rst),
		.launch_in(launch),
		.q_out(q_k),
		.oe_out(oe_k)
	);

	assign dq_out = parked ? q_k : q_c;
	assign dq_oe_out = parked ? oe_k : oe_c;

	// ------------------------------------------------------------
	// system domain: counters from toggles
	// ------------------------------------------------------------
	// bit 0 of each sync chain feeds only bit 1
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			wr_tog_sync <= 3'h0;
			rd_tog_sync <= 3'h0;
		end
		else
		begin
			wr_tog_sync <= {wr_tog_sync[1:0], wr_tog};
			rd_tog_sync <= {rd_tog_sync[1:0], rd_tog};
		end
	end

	// counters wrap; software takes differences
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			write_count <= COUNT_RESET;
			read_count <= COUNT_RESET;
		end
		else
		begin
			if (wr_tog_sync[2] ^ wr_tog_sync[1])
				write_count <= write_count + 16'h0001;
			if (rd_tog_sync[2] ^ rd_tog_sync[1])
				read_count <= read_count + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// system domain: register port
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			ctrl_enable <= CTRL_ENABLE_RESET;
		else if (reg_write_in && reg_addr_in == CTRL_OFFSET)
			ctrl_enable <= reg_wdata_in[CTRL_ENABLE_BIT];
	end

	// unmapped and idle reads return zero
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			reg_rdata_out <= 32'h0;
		else if (reg_read_in && reg_addr_in == CTRL_OFFSET)
			reg_rdata_out <= 32'(ctrl_enable) << CTRL_ENABLE_BIT;
		else if (reg_read_in && reg_addr_in == STATUS_OFFSET)
			reg_rdata_out <= (32'(read_count) << STATUS_READS_LSB)
				| (32'(write_count) << STATUS_WRITES_LSB);
		else
			reg_rdata_out <= 32'h0;
	end

endmodule // ddr_sram_byte_write_port
